// *** src/fep_pkg.sv ***
// Package of constants for the flash erase and block protection controller.
package fep_pkg;
    localparam int unsigned ARRAY_BYTES  = 16384;
    localparam int unsigned WORD_BYTES   = 4;
    localparam int unsigned NUM_WORDS    = ARRAY_BYTES / WORD_BYTES;
    localparam int unsigned ADDR_W       = 12;
    localparam int unsigned ERASE_BYTES  = 1024;
    localparam int unsigned ERASE_WORDS  = ERASE_BYTES / WORD_BYTES;
    localparam int unsigned WIB_W        = 8;
    localparam int unsigned NUM_EBLK     = ARRAY_BYTES / ERASE_BYTES;
    localparam int unsigned EBLK_W       = 4;
    localparam int unsigned NUM_PUNIT    = NUM_EBLK / 2;
    localparam int unsigned PUNIT_W      = 3;
    localparam logic [31:0] ERASED_WORD  = 32'hffff_ffff;
    localparam logic [7:0]  PROT_RESET   = 8'h00;

    typedef enum logic [3:0] {
        FEP_IDLE  = 4'b0001,
        FEP_ERASE = 4'b0010,
        FEP_PROG  = 4'b0100,
        FEP_DONE  = 4'b1000
    } fep_state_t;
endpackage : fep_pkg

// *** src/fep_array.sv ***
// Flash cell array with one combinational read port and one clocked write port.
`timescale 1ns/1ns
`default_nettype none
module fep_array
    import fep_pkg::*;
(
    input  wire logic                   mclk_in,
    input  wire logic [fep_pkg::ADDR_W-1:0] raddr_in,
    output logic      [31:0]            rdata_out,
    input  wire logic                   we_in,
    input  wire logic [fep_pkg::ADDR_W-1:0] waddr_in,
    input  wire logic [31:0]            wdata_in
);
    import fep_pkg::*;

    // No reset: the cells model non-volatile storage.
    logic [31:0] mem [NUM_WORDS];

    // The read is registered by the caller, so this output stays combinational.
    assign rdata_out = mem[raddr_in];

    always_ff @(posedge mclk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end
endmodule // fep_array
`default_nettype wire

// *** src/fep_ctrl.sv ***
// Flash controller: reads, block erase, programming and 2 KB protection.
`timescale 1ns/1ns
`default_nettype none
module fep_ctrl
    import fep_pkg::*;
(
    input  wire logic                       mclk_in,
    input  wire logic                       resetn_in,
    input  wire logic                       ifetch_req_in,
    input  wire logic [fep_pkg::ADDR_W-1:0] ifetch_addr_in,
    input  wire logic                       dread_req_in,
    input  wire logic [fep_pkg::ADDR_W-1:0] dread_addr_in,
    input  wire logic                       dbg_req_in,
    input  wire logic [fep_pkg::ADDR_W-1:0] dbg_addr_in,
    output logic                            rvalid_out,
    output logic      [31:0]                rdata_out,
    output logic                            rdenied_out,
    input  wire logic                       erase_req_in,
    input  wire logic [fep_pkg::EBLK_W-1:0] erase_blk_in,
    input  wire logic                       prog_req_in,
    input  wire logic [fep_pkg::ADDR_W-1:0] prog_addr_in,
    input  wire logic [31:0]                prog_data_in,
    input  wire logic                       prot_we_in,
    input  wire logic [fep_pkg::PUNIT_W-1:0] prot_unit_in,
    input  wire logic                       prot_ro_in,
    input  wire logic                       prot_xo_in,
    input  wire logic                       err_clr_in,
    output logic                            busy_out,
    output logic                            done_out,
    output logic                            access_err_out,
    output logic      [7:0]                 ro_out,
    output logic      [7:0]                 xo_out
);
    import fep_pkg::*;

    fep_state_t              state_reg;
    logic [WIB_W-1:0]        ecnt_reg;
    logic [EBLK_W-1:0]       eblk_reg;
    logic [7:0]              ro_reg;
    logic [7:0]              xo_reg;
    logic                    err_reg;
    logic                    rvalid_reg;
    logic                    rden_reg;
    logic                    we;
    logic [ADDR_W-1:0]       waddr;
    logic [31:0]             wdata;
    logic [ADDR_W-1:0]       raddr;
    logic [PUNIT_W-1:0]      r_unit;
    logic                    r_data_side;
    logic                    r_deny;
    logic                    r_any;
    logic [PUNIT_W-1:0]      e_unit;
    logic [PUNIT_W-1:0]      p_unit;
    logic                    e_prot;
    logic                    p_prot;
    logic                    e_go;
    logic                    p_go;
    logic                    bad_op;
    logic [31:0]             arr_rdata;
    logic                    busy_reg;
    logic                    done_reg;
    logic [31:0]             rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read path. Fetch wins over data, data over debugger.
    always_comb begin
        r_any       = ifetch_req_in | dread_req_in | dbg_req_in;
        r_data_side = !ifetch_req_in;
        if (ifetch_req_in) begin
            raddr = ifetch_addr_in;
        end else if (dread_req_in) begin
            raddr = dread_addr_in;
        end else begin
            raddr = dbg_addr_in;
        end
        r_unit = raddr[ADDR_W-1 -: PUNIT_W];
        r_deny = r_any && r_data_side && xo_reg[r_unit];
    end

    fep_array u_array (
        .mclk_in   (mclk_in),
        .raddr_in  (raddr),
        .rdata_out (arr_rdata),
        .we_in     (we),
        .waddr_in  (waddr),
        .wdata_in  (wdata)
    );

    // Single-cycle answer: valid and the deny flag follow the request by one edge.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rvalid_reg <= 1'b0;
            rden_reg   <= 1'b0;
            rdata_reg  <= '0;
        end else begin
            rvalid_reg <= r_any;
            rden_reg   <= r_deny;
            // Denied reads return zero so no execute-only contents leak out.
            rdata_reg  <= r_deny ? 32'h0000_0000 : arr_rdata;
        end
    end

    assign rvalid_out  = rvalid_reg;
    assign rdenied_out = rden_reg;
    assign rdata_out   = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Protection bits, one pair per 2 KB unit; once set they stay until reset.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ro_reg <= PROT_RESET;
            xo_reg <= PROT_RESET;
        end else if (prot_we_in) begin
            ro_reg[prot_unit_in] <= ro_reg[prot_unit_in] | prot_ro_in;
            xo_reg[prot_unit_in] <= xo_reg[prot_unit_in] | prot_xo_in;
        end
    end

    assign ro_out = ro_reg;
    assign xo_out = xo_reg;

    ////////////////////////////////////////////////////////////////////////
    // Erase and program sequencer.
    always_comb begin
        e_unit = erase_blk_in[EBLK_W-1:1];
        p_unit = prog_addr_in[ADDR_W-1 -: PUNIT_W];
        e_prot = ro_reg[e_unit] | xo_reg[e_unit];
        p_prot = ro_reg[p_unit] | xo_reg[p_unit];
        e_go   = (state_reg == FEP_IDLE) && erase_req_in && !e_prot;
        p_go   = (state_reg == FEP_IDLE) && !erase_req_in && prog_req_in && !p_prot;
        bad_op = (state_reg == FEP_IDLE)
               && ((erase_req_in && e_prot) || (!erase_req_in && prog_req_in && p_prot))
               || r_deny;
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= FEP_IDLE;
            ecnt_reg  <= '0;
            eblk_reg  <= '0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            // Busy and done are kept as flags beside the state so both outputs are flip-flops.
            unique case (state_reg)
                FEP_IDLE: begin
                    ecnt_reg <= '0;
                    if (e_go) begin
                        eblk_reg  <= erase_blk_in;
                        state_reg <= FEP_ERASE;
                        busy_reg  <= 1'b1;
                    end else if (p_go) begin
                        state_reg <= FEP_PROG;
                        busy_reg  <= 1'b1;
                    end
                end
                FEP_ERASE: begin
                    ecnt_reg <= ecnt_reg + 1'b1;
                    if (ecnt_reg == WIB_W'(ERASE_WORDS - 1)) begin
                        state_reg <= FEP_DONE;
                        done_reg  <= 1'b1;
                    end
                end
                FEP_PROG: begin
                    state_reg <= FEP_DONE;
                    done_reg  <= 1'b1;
                end
                FEP_DONE: begin
                    state_reg <= FEP_IDLE;
                    busy_reg  <= 1'b0;
                    done_reg  <= 1'b0;
                end
            endcase
        end
    end

    // Program latches its word on the accepting edge.
    logic [ADDR_W-1:0] paddr_reg;
    logic [31:0]       pdata_reg;
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            paddr_reg <= '0;
            pdata_reg <= '0;
        end else if (p_go) begin
            paddr_reg <= prog_addr_in;
            pdata_reg <= prog_data_in;
        end
    end

    always_comb begin
        we    = 1'b0;
        waddr = paddr_reg;
        wdata = pdata_reg;
        if (state_reg == FEP_ERASE) begin
            we    = 1'b1;
            waddr = {eblk_reg, ecnt_reg};
            wdata = ERASED_WORD;
        end else if (state_reg == FEP_PROG) begin
            // Programming writes the latched word as it is, so it can set bits as well as clear them.
            we = 1'b1;
        end
    end

    assign busy_out = busy_reg;
    assign done_out = done_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sticky access error; a new error in the clear cycle wins.
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            err_reg <= 1'b0;
        end else if (bad_op) begin
            err_reg <= 1'b1;
        end else if (err_clr_in) begin
            err_reg <= 1'b0;
        end
    end

    assign access_err_out = err_reg;

    ////////////////////////////////////////////////////////////////////////
    property p_read_one_cycle;
        @(posedge mclk_in) disable iff (!resetn_in)
        r_any |=> rvalid_out;
    endproperty
    a_read_one_cycle: assert property (p_read_one_cycle) else $error("read not answered");

    property p_erase_len;
        @(posedge mclk_in) disable iff (!resetn_in)
        e_go |=> (state_reg == FEP_ERASE) [*8];
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase ended early");

    property p_erase_ones;
        @(posedge mclk_in) disable iff (!resetn_in)
        (state_reg == FEP_ERASE) |-> we && (wdata == ERASED_WORD);
    endproperty
    a_erase_ones: assert property (p_erase_ones) else $error("erase writes non-ones");

    property p_erase_block;
        @(posedge mclk_in) disable iff (!resetn_in)
        we && (state_reg == FEP_ERASE) |-> waddr[ADDR_W-1 -: EBLK_W] == eblk_reg;
    endproperty
    a_erase_block: assert property (p_erase_block) else $error("erase left its block");

    property p_no_write_prot;
        @(posedge mclk_in) disable iff (!resetn_in)
        we |-> !(ro_reg[waddr[ADDR_W-1 -: PUNIT_W]] | xo_reg[waddr[ADDR_W-1 -: PUNIT_W]]);
    endproperty
    a_no_write_prot: assert property (p_no_write_prot) else $error("protected write");

    property p_xo_refuse;
        @(posedge mclk_in) disable iff (!resetn_in)
        (state_reg == FEP_IDLE) && erase_req_in && xo_reg[e_unit] |=> state_reg == FEP_IDLE;
    endproperty
    a_xo_refuse: assert property (p_xo_refuse) else $error("xo erase accepted");

    property p_xo_deny;
        @(posedge mclk_in) disable iff (!resetn_in)
        r_any && !ifetch_req_in && xo_reg[r_unit] |=> rdenied_out && rdata_out == 32'h0;
    endproperty
    a_xo_deny: assert property (p_xo_deny) else $error("xo data read leaked");

    property p_err_raise;
        @(posedge mclk_in) disable iff (!resetn_in)
        bad_op |=> access_err_out;
    endproperty
    a_err_raise: assert property (p_err_raise) else $error("error not raised");

    property p_unit_indep;
        @(posedge mclk_in) disable iff (!resetn_in)
        prot_we_in |=> (ro_reg & ~(8'h01 << $past(prot_unit_in)))
                     == ($past(ro_reg) & ~(8'h01 << $past(prot_unit_in)));
    endproperty
    a_unit_indep: assert property (p_unit_indep) else $error("other unit changed");
endmodule // fep_ctrl
`default_nettype wire

// *** dv/fep_core_model.sv ***
// Behavioural processor-side reader issuing fetch, data and debugger reads.
`timescale 1ns/1ns
`default_nettype none
module fep_core_model
    import fep_pkg::*;
(
    input  wire logic                       mclk_in,
    output logic                            ifetch_req_out,
    output logic                            dread_req_out,
    output logic                            dbg_req_out,
    output logic      [fep_pkg::ADDR_W-1:0] addr_out,
    input  wire logic                       rvalid_in,
    input  wire logic [31:0]                rdata_in,
    input  wire logic                       rdenied_in
);
    initial begin
        ifetch_req_out = 1'b0;
        dread_req_out  = 1'b0;
        dbg_req_out    = 1'b0;
        addr_out       = '0;
    end

    // Kind 0 is a fetch, 1 a data read and 2 a debugger read.
    task automatic read(input int kind, input logic [ADDR_W-1:0] a,
                        output logic ok, output logic [31:0] d, output logic den);
        @(posedge mclk_in);
        ifetch_req_out <= (kind == 0);
        dread_req_out  <= (kind == 1);
        dbg_req_out    <= (kind == 2);
        addr_out       <= a;
        @(posedge mclk_in);
        ifetch_req_out <= 1'b0;
        dread_req_out  <= 1'b0;
        dbg_req_out    <= 1'b0;
        // Released address lines flip, so a stale address can never pass for a live one.
        addr_out       <= ~a;
        #1;
        ok  = rvalid_in;
        d   = rdata_in;
        den = rdenied_in;
    endtask
endmodule // fep_core_model
`default_nettype wire

// *** dv/flash_erase_and_block_protection_test.sv ***
// Self-checking testbench for the flash controller with a reader model.
`timescale 1ns/1ns
`default_nettype none
module flash_erase_and_block_protection_test;
    import fep_pkg::*;
    logic mclk_in = 1'b0, resetn_in = 1'b0, erase_req_in, prog_req_in, prot_we_in;
    logic prot_ro_in, prot_xo_in, err_clr_in;
    logic [3:0] erase_blk_in;
    logic [11:0] prog_addr_in;
    logic [31:0] prog_data_in;
    logic [2:0] prot_unit_in;
    wire logic ifetch_req_in, dread_req_in, dbg_req_in, rvalid_out, rdenied_out;
    wire logic busy_out, done_out, access_err_out;
    wire logic [11:0] rd_addr;
    wire logic [31:0] rdata_out;
    wire logic [7:0] ro_out, xo_out;
    int n_mismatch = 0;
    int checks_done = 0;

    always #4 mclk_in = ~mclk_in;

    fep_ctrl u_dut (.mclk_in, .resetn_in, .ifetch_req_in, .ifetch_addr_in(rd_addr),
        .dread_req_in, .dread_addr_in(rd_addr), .dbg_req_in, .dbg_addr_in(rd_addr),
        .rvalid_out, .rdata_out, .rdenied_out, .erase_req_in, .erase_blk_in, .prog_req_in,
        .prog_addr_in, .prog_data_in, .prot_we_in, .prot_unit_in, .prot_ro_in, .prot_xo_in,
        .err_clr_in, .busy_out, .done_out, .access_err_out, .ro_out, .xo_out);
    fep_core_model u_core (.mclk_in, .ifetch_req_out(ifetch_req_in),
        .dread_req_out(dread_req_in), .dbg_req_out(dbg_req_in), .addr_out(rd_addr),
        .rvalid_in(rvalid_out), .rdata_in(rdata_out), .rdenied_in(rdenied_out));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        checks_done++;
        if (act !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic rd(input int kind, input logic [11:0] a, input logic [31:0] ed,
                      input logic eden);
        logic ok, den;
        logic [31:0] d;
        u_core.read(kind, a, ok, d, den);
        chk({31'h0, ok}, 32'h1);
        chk(d, ed);
        chk({31'h0, den}, {31'h0, eden});
    endtask

    // A cycle count of zero means the request is expected to be refused.
    task automatic op(input logic er, input logic [3:0] b, input logic [11:0] a,
                      input logic [31:0] d, input int cyc);
        int n;
        @(posedge mclk_in);
        erase_req_in <= er;
        prog_req_in  <= !er;
        erase_blk_in <= b;
        prog_addr_in <= a;
        prog_data_in <= d;
        @(posedge mclk_in);
        erase_req_in <= 1'b0;
        prog_req_in  <= 1'b0;
        #1;
        chk({31'h0, busy_out}, {31'h0, cyc != 0});
        // The request cycle counts as the first of the expected cycles.
        n = (cyc != 0) ? 1 : 0;
        while (cyc != 0 && done_out !== 1'b1 && n < 400) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        if (cyc == 0) begin
            @(posedge mclk_in);
            #1;
            chk({31'h0, busy_out}, 32'h0);
        end
        chk(n, cyc);
        chk({31'h0, access_err_out}, {31'h0, cyc == 0});
    endtask

    task automatic prot(input logic [2:0] u, input logic ro, input logic xo);
        @(posedge mclk_in);
        prot_we_in   <= 1'b1;
        prot_unit_in <= u;
        prot_ro_in   <= ro;
        prot_xo_in   <= xo;
        @(posedge mclk_in);
        prot_we_in   <= 1'b0;
        #1;
    endtask

    task automatic clr(input logic exp);
        @(posedge mclk_in);
        err_clr_in <= 1'b1;
        #1;
        chk({31'h0, access_err_out}, {31'h0, exp});
        @(posedge mclk_in);
        err_clr_in <= 1'b0;
        #1;
        chk({31'h0, access_err_out}, 32'h0);
    endtask

    task automatic print_verdict();
        $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_basic();
        chk({8'h0, ro_out, xo_out, 6'h0, busy_out, access_err_out}, 32'h0);
        op(1'b0, 4'h0, 12'h005, 32'h1234_5678, 2);
        rd(0, 12'h005, 32'h1234_5678, 1'b0);
        rd(1, 12'h005, 32'h1234_5678, 1'b0);
        $display("Test basic read and program done");
    endtask

    task automatic t_erase();
        op(1'b0, 4'h0, 12'h200, 32'ha5a5_0001, 2);
        op(1'b0, 4'h0, 12'h2ff, 32'h0000_0000, 2);
        op(1'b0, 4'h0, 12'h300, 32'h5a5a_0003, 2);
        op(1'b1, 4'h2, 12'h000, 32'h0, 257);
        rd(1, 12'h200, ERASED_WORD, 1'b0);
        rd(1, 12'h2ff, ERASED_WORD, 1'b0);
        rd(1, 12'h300, 32'h5a5a_0003, 1'b0);
        $display("Test block erase done");
    endtask

    task automatic t_readonly();
        prot(3'h1, 1'b1, 1'b0);
        chk({16'h0, ro_out, xo_out}, 32'h0200);
        op(1'b1, 4'h3, 12'h000, 32'h0, 0);
        clr(1'b1);
        op(1'b0, 4'h0, 12'h300, 32'h0, 0);
        clr(1'b1);
        rd(1, 12'h300, 32'h5a5a_0003, 1'b0);
        $display("Test read-only unit done");
    endtask

    task automatic t_execonly();
        op(1'b0, 4'h0, 12'h400, 32'hc0de_0004, 2);
        prot(3'h2, 1'b0, 1'b1);
        chk({16'h0, ro_out, xo_out}, 32'h0204);
        rd(0, 12'h400, 32'hc0de_0004, 1'b0);
        rd(1, 12'h400, 32'h0, 1'b1);
        clr(1'b1);
        rd(2, 12'h400, 32'h0, 1'b1);
        clr(1'b1);
        op(1'b1, 4'h5, 12'h000, 32'h0, 0);
        clr(1'b1);
        op(1'b0, 4'h0, 12'h401, 32'h0, 0);
        clr(1'b1);
        rd(0, 12'h400, 32'hc0de_0004, 1'b0);
        $display("Test execute-only unit done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        {erase_req_in, prog_req_in, prot_we_in, prot_ro_in, prot_xo_in, err_clr_in} = '0;
        erase_blk_in = '0;
        prog_addr_in = '0;
        prog_data_in = '0;
        prot_unit_in = '0;
        repeat (4) @(posedge mclk_in);
        resetn_in <= 1'b1;
        t_basic();
        t_erase();
        t_readonly();
        t_execonly();
        print_verdict();
    end

    // The tests need about 330 cycles, so 5000 cycles means a hang.
    initial begin
        #40000;
        n_mismatch++;
        print_verdict();
    end
endmodule // flash_erase_and_block_protection_test
`default_nettype wire
